// File: pulse_input_status_ports.v
// Purpose: Mode status port, operator switch port, scan image stream and
//          display indexing of a four-channel pulse input board.
// Assumes: One 10 MHz clock; switches, pulse inputs and counter-enable
//          lines arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "pulse_input_status_consts.vh"
`default_nettype none

// Small synchronous FIFO; output data come from the storage flops
module scan_byte_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   input wire core_clk_i,
   input wire rst_b_i,
   input wire clk_en_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
   reg [AW-1:0] wr_ptr; // Next slot to fill
   reg [AW-1:0] rd_ptr; // Oldest slot
   reg [AW:0] fill; // Words held
   wire push; // Word accepted this cycle
   wire pop; // Word delivered this cycle

   assign in_ready_o = (fill != DEPTH[AW:0]);
   assign out_valid_o = (fill != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = clk_en_i & in_valid_i & in_ready_o;
   assign pop = clk_en_i & out_valid_o & out_ready_i;

   // Storage is not reset; empty flag hides stale words
   always @(posedge core_clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointer and fill bookkeeping
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop)
         begin
            fill <= fill + {{AW{1'b0}}, 1'b1};
         end
         else if (pop && !push)
         begin
            fill <= fill - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

module pulse_input_status_ports
(
   input wire core_clk_i,
   input wire rst_b_i,
   input wire clk_en_i,
   input wire [3:0] pulse_in_i,
   input wire low_pair_mode_switch_i,
   input wire high_pair_mode_switch_i,
   input wire low_pair_count_on_i,
   input wire high_pair_count_on_i,
   input wire plus_key_switch_i,
   input wire minus_key_switch_i,
   input wire step_key_switch_i,
   input wire [3:0] sixteen_way_selector_i,
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   input wire scan_req_i,
   output wire scan_busy_o,
   output wire scan_valid_o,
   input wire scan_ready_i,
   output wire [7:0] scan_byte_o,
   output wire tuning_mode_o,
   output reg [7:0] display_msg_o,
   output reg [7:0] display_value_o
);
   // Scan sequencer states, one-hot
   localparam SCAN_IDLE = 2'b01;
   localparam SCAN_LOAD = 2'b10;
   // Tuning stages, one-hot
   localparam TUNE_VIEW = 2'b01;
   localparam TUNE_EDIT = 2'b10;

   wire [`PIN_WIDTH-1:0] pins_raw; // All asynchronous pins
   reg [`PIN_WIDTH-1:0] pins_meta; // First sync stage, read only by stage two
   reg [`PIN_WIDTH-1:0] pins_sync; // Settled pin levels
   reg [`PIN_WIDTH-1:0] pins_prev; // Previous settled levels for edges
   wire [`PIN_WIDTH-1:0] pins_rise; // Rising edge per pin
   reg [7:0] first_port_control; // Software control byte
   reg [1:0] scan_state; // Scan sequencer state
   reg [1:0] next_scan_state; // Next scan state
   reg [2:0] scan_idx; // Byte being loaded
   reg [63:0] scan_snap; // Point images frozen at request
   wire [63:0] point_img; // Live point images
   wire fifo_in_ready; // FIFO has room
   wire fifo_push_valid; // Sequencer offers a byte
   wire [7:0] fifo_in_byte; // Byte offered
   wire [7:0] mode_port; // Counter status and mode image
   wire [7:0] switch_port; // Key and selector image
   wire [1:0] pair_rate; // Rate mode per pair
   wire [1:0] pair_count_on; // Counter enable per pair
   wire [3:0] sel; // Settled selector position
   wire tuning; // Selector in tuning range
   wire key_en; // Keys honoured
   reg [1:0] tune_stage; // Tuning stage
   reg [7:0] tune_mem [0:`TUNE_ENTRIES-1]; // Tuning parameter values
   reg [7:0] edit_value; // Value under edit
   reg [7:0] shown_value; // Readout latched by step in normal mode
   reg [3:0] sel_prev; // Selector last cycle, to drop a stale edit
   wire [2:0] tune_idx; // Parameter chosen by selector
   wire [3:0] tune_off; // Selector offset into tuning range
   reg [7:0] readout_value; // Live readout for the selector
   integer i; // Reset loop index

   assign pins_raw = {sixteen_way_selector_i, high_pair_count_on_i, low_pair_count_on_i,
                      high_pair_mode_switch_i, low_pair_mode_switch_i, step_key_switch_i,
                      minus_key_switch_i, plus_key_switch_i, pulse_in_i};

   // Two-flop synchroniser plus edge history on every pin
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pins_meta <= {`PIN_WIDTH{1'b0}};
         pins_sync <= {`PIN_WIDTH{1'b0}};
         pins_prev <= {`PIN_WIDTH{1'b0}};
      end
      else if (clk_en_i)
      begin
         pins_meta <= pins_raw;
         pins_sync <= pins_meta;
         pins_prev <= pins_sync;
      end
   end

   assign pins_rise = pins_sync & ~pins_prev;
   // Switch high selects rate for its pair, low selects totalizing
   assign pair_rate = {pins_sync[`PIN_HIGH_MODE], pins_sync[`PIN_LOW_MODE]};
   assign pair_count_on = {pins_sync[`PIN_HIGH_COUNT], pins_sync[`PIN_LOW_COUNT]};
   assign sel = pins_sync[`PIN_SEL_LSB+3:`PIN_SEL_LSB];
   assign tuning = (sel >= `SEL_FIRST_TUNE);
   assign tuning_mode_o = tuning;
   assign key_en = first_port_control[`CTRL_KEY_EN_BIT];

   // Per-channel pulse counting; pair mode chooses total or rate sample
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1)
      begin : chan
         reg [15:0] count; // Running count of pulses
         reg [15:0] sample; // Last completed rate sample
         wire rate_mode; // Pair is in rate mode
         wire sample_done; // Sampling period just completed
         assign rate_mode = pair_rate[ch/2];
         // Counter-enable only has meaning in rate mode
         assign sample_done = rate_mode & pins_rise[`PIN_LOW_COUNT + ch/2];
         always @(posedge core_clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               count <= `ZERO_COUNT;
               sample <= `ZERO_COUNT;
            end
            else if (clk_en_i)
            begin
               if (sample_done)
               begin
                  // Restart the window; a pulse in this cycle opens the next one
                  sample <= count;
                  count <= pins_rise[`PIN_PULSE_LSB + ch] ? `ONE_COUNT : `ZERO_COUNT;
               end
               else if (pins_rise[`PIN_PULSE_LSB + ch] && first_port_control[`CTRL_COUNT_EN_BIT])
               begin
                  count <= count + `ONE_COUNT;
               end
            end
         end
         // Two consecutive points per channel, low byte first
         assign point_img[16*ch+15:16*ch] = rate_mode ? sample : count;
      end
   endgenerate

   // Mode status port image; upper bits read as zero
   assign mode_port = {4'h0,
                       pair_rate[1],
                       pair_rate[0],
                       pair_count_on[1],
                       pair_count_on[0]};

   // Switch port image: step, minus, plus, selector
   assign switch_port = {1'b0, pins_sync[`PIN_STEP], pins_sync[`PIN_MINUS],
                         pins_sync[`PIN_PLUS], sel};

   // Register write: control byte only; other addresses ignore writes
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         first_port_control <= `CTRL_RESET;
      end
      else if (clk_en_i && reg_wr_i && reg_addr_i == `CTRL_PORT_ADDR)
      begin
         first_port_control <= reg_wdata_i;
      end
   end

   // Register read: data valid only in the cycle after the strobe
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         reg_rdata_o <= `ZERO_BYTE;
      end
      else if (clk_en_i)
      begin
         if (!reg_rd_i)
         begin
            reg_rdata_o <= `ZERO_BYTE;
         end
         else if (reg_addr_i == `MODE_PORT_ADDR)
         begin
            reg_rdata_o <= mode_port;
         end
         else if (reg_addr_i == `SWITCH_PORT_ADDR)
         begin
            reg_rdata_o <= switch_port;
         end
         else if (reg_addr_i == `CTRL_PORT_ADDR)
         begin
            reg_rdata_o <= first_port_control;
         end
         else
         begin
            // Unmapped address reads zero
            reg_rdata_o <= `ZERO_BYTE;
         end
      end
   end

   // Scan sequencer next state; a request is a bare strobe with no payload
   always @*
   begin
      next_scan_state = scan_state;
      case (scan_state)
         SCAN_IDLE:
         begin
            if (scan_req_i && first_port_control[`CTRL_SCAN_EN_BIT])
            begin
               next_scan_state = SCAN_LOAD;
            end
         end
         SCAN_LOAD:
         begin
            if (fifo_in_ready && scan_idx == `SCAN_LAST_POINT)
            begin
               next_scan_state = SCAN_IDLE;
            end
         end
         default:
         begin
            next_scan_state = SCAN_IDLE;
         end
      endcase
   end

   // Scan sequencer registers; snapshot keeps the eight bytes coherent
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scan_state <= SCAN_IDLE;
         scan_idx <= 3'h0;
         scan_snap <= 64'h0000_0000_0000_0000;
      end
      else if (clk_en_i)
      begin
         scan_state <= next_scan_state;
         if (scan_state == SCAN_IDLE && next_scan_state == SCAN_LOAD)
         begin
            scan_snap <= point_img;
            scan_idx <= 3'h0;
         end
         else if (scan_state == SCAN_LOAD && fifo_in_ready)
         begin
            scan_idx <= scan_idx + 3'h1;
         end
      end
   end

   assign scan_busy_o = (scan_state == SCAN_LOAD);
   assign fifo_push_valid = (scan_state == SCAN_LOAD);
   // Bytes 0 to 7 leave in order; a stalled reader stalls the sequencer
   assign fifo_in_byte = scan_snap[8*scan_idx +: 8];

   scan_byte_fifo
   #(
      .WIDTH(8),
      .DEPTH(4),
      .AW(2)
   )
   scan_byte_fifo_i
   (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(fifo_push_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_byte),
      .out_valid_o(scan_valid_o),
      .out_ready_i(scan_ready_i),
      .out_data_o(scan_byte_o)
   );

   assign tune_off = sel - `SEL_FIRST_TUNE;
   assign tune_idx = tune_off[2:0];

   // Readout source for normal positions
   always @*
   begin
      readout_value = `ZERO_BYTE;
      if (sel <= `SEL_LAST_READOUT)
      begin
         if (sel == `SEL_LAST_READOUT)
         begin
            readout_value = mode_port;
         end
         else
         begin
            readout_value = point_img[8*sel[2:0] +: 8];
         end
      end
   end

   // Operator keys: step, plus and minus act on rising edges only
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tune_stage <= TUNE_VIEW;
         edit_value <= `ZERO_BYTE;
         shown_value <= `ZERO_BYTE;
         sel_prev <= 4'h0;
         for (i = 0; i < `TUNE_ENTRIES; i = i + 1)
         begin
            tune_mem[i] <= `ZERO_BYTE;
         end
      end
      else if (clk_en_i)
      begin
         sel_prev <= sel;
         if (sel != sel_prev)
         begin
            // Turning the selector abandons an unsaved edit
            tune_stage <= TUNE_VIEW;
         end
         else if (key_en && !tuning)
         begin
            if (pins_rise[`PIN_STEP])
            begin
               shown_value <= readout_value;
            end
         end
         else if (key_en)
         begin
            case (tune_stage)
               TUNE_VIEW:
               begin
                  if (pins_rise[`PIN_STEP])
                  begin
                     edit_value <= tune_mem[tune_idx];
                     tune_stage <= TUNE_EDIT;
                  end
               end
               TUNE_EDIT:
               begin
                  if (pins_rise[`PIN_STEP])
                  begin
                     tune_mem[tune_idx] <= edit_value;
                     tune_stage <= TUNE_VIEW;
                  end
                  else if (pins_rise[`PIN_PLUS] && !pins_rise[`PIN_MINUS])
                  begin
                     edit_value <= edit_value + `ONE_BYTE;
                  end
                  else if (pins_rise[`PIN_MINUS] && !pins_rise[`PIN_PLUS])
                  begin
                     edit_value <= edit_value - `ONE_BYTE;
                  end
               end
               default:
               begin
                  tune_stage <= TUNE_VIEW;
               end
            endcase
         end
      end
   end

   // Display: message number is position times eight, edit page above 128
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         display_msg_o <= `ZERO_BYTE;
         display_value_o <= `ZERO_BYTE;
      end
      else if (clk_en_i)
      begin
         display_msg_o <= {(tune_stage == TUNE_EDIT) & tuning, sel, 3'b000};
         if (!tuning)
         begin
            display_value_o <= shown_value;
         end
         else if (tune_stage == TUNE_EDIT)
         begin
            display_value_o <= edit_value;
         end
         else
         begin
            display_value_o <= tune_mem[tune_idx];
         end
      end
   end
endmodule

`default_nettype wire

// File: pulse_input_status_consts.vh
// Purpose: Shared constants for the pulse input status and operator port block.
// Assumes: Registers are eight bits wide on a four-bit port address.
// Notes: Definitions only; included by bare name.
`ifndef PULSE_INPUT_STATUS_CONSTS_VH
`define PULSE_INPUT_STATUS_CONSTS_VH

// Register port addresses
`define SWITCH_PORT_ADDR 4'h3
`define MODE_PORT_ADDR 4'h8
`define CTRL_PORT_ADDR 4'h9

// Control register reset pattern 00001011
`define CTRL_RESET 8'h0B

// Control register field positions
`define CTRL_SCAN_EN_BIT 0
`define CTRL_KEY_EN_BIT 1
`define CTRL_COUNT_EN_BIT 3

// Mode port field positions
`define MODE_LOW_COUNT_BIT 0
`define MODE_HIGH_COUNT_BIT 1
`define MODE_LOW_RATE_BIT 2
`define MODE_HIGH_RATE_BIT 3

// Switch port field positions
`define SW_SEL_LSB 0
`define SW_SEL_MSB 3
`define SW_PLUS_BIT 4
`define SW_MINUS_BIT 5
`define SW_STEP_BIT 6

// Synchronised pin vector layout
`define PIN_PULSE_LSB 0
`define PIN_PLUS 4
`define PIN_MINUS 5
`define PIN_STEP 6
`define PIN_LOW_MODE 7
`define PIN_HIGH_MODE 8
`define PIN_LOW_COUNT 9
`define PIN_HIGH_COUNT 10
`define PIN_SEL_LSB 11
`define PIN_WIDTH 15

// Selector positions and display indexing
`define SEL_LAST_READOUT 4'h8
`define SEL_FIRST_TUNE 4'h9
`define TUNE_ENTRIES 7
`define SCAN_POINTS 8
`define SCAN_LAST_POINT 3'h7
`define ZERO_BYTE 8'h00
`define ZERO_COUNT 16'h0000
`define ONE_COUNT 16'h0001
`define ONE_BYTE 8'h01

`endif

// File: pis_chk_sva.sv
// Purpose: Port-level checks for the pulse input status block.
// Assumes: clk_en_i held high, so pins reach the logic two edges late.
// Notes: Pin checks wait for pins held steady, to ride out the synchroniser.
`timescale 1ns/1ps
`include "pulse_input_status_consts.vh"
`default_nettype none
module pis_chk
(
   input wire core_clk_i,
   input wire rst_b_i,
   input wire low_pair_mode_switch_i,
   input wire low_pair_count_on_i,
   input wire [3:0] sixteen_way_selector_i,
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire scan_req_i,
   input wire scan_busy_o,
   input wire scan_valid_o,
   input wire scan_ready_i,
   input wire [7:0] scan_byte_o,
   input wire tuning_mode_o,
   input wire [7:0] display_msg_o
);
   // Mirror of the control register; scans are only taken when bit 0 is set
   reg [7:0] ctrl_q;
   // High once software has written the control register
   reg ctrl_wr;
   // Track control writes; the mirror resets like the real register
   always @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctrl_q <= `CTRL_RESET;
         ctrl_wr <= 1'b0;
      end
      else if (reg_wr_i && reg_addr_i == `CTRL_PORT_ADDR)
      begin
         ctrl_q <= reg_wdata_i;
         ctrl_wr <= 1'b1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_rate_flag_read: assert property (low_pair_mode_switch_i [*4] ##0
      (reg_rd_i && reg_addr_i == `MODE_PORT_ADDR) |=> reg_rdata_o[`MODE_LOW_RATE_BIT])
      else $error("rate flag not set for low pair");
   a_count_off_read: assert property (!low_pair_count_on_i [*4] ##0
      (reg_rd_i && reg_addr_i == `MODE_PORT_ADDR) |=> !reg_rdata_o[`MODE_LOW_COUNT_BIT])
      else $error("count enable bit set while pin low");
   a_tune_sel_high: assert property ((sixteen_way_selector_i >= `SEL_FIRST_TUNE) [*3] |=> tuning_mode_o)
      else $error("tuning not entered at high selector");
   a_tune_sel_low: assert property ((sixteen_way_selector_i <= `SEL_LAST_READOUT) [*3] |=> !tuning_mode_o)
      else $error("tuning shown at readout selector");
   a_switch_top_bit: assert property (reg_rd_i && reg_addr_i == `SWITCH_PORT_ADDR |=> !reg_rdata_o[7])
      else $error("switch port top bit set");
   a_ctrl_init_val: assert property (reg_rd_i && reg_addr_i == `CTRL_PORT_ADDR && !ctrl_wr
      |=> reg_rdata_o == `CTRL_RESET)
      else $error("control register not at reset pattern");
   a_msg_eight_step: assert property ($stable(sixteen_way_selector_i) [*4]
      |=> display_msg_o[6:0] == {$past(sixteen_way_selector_i), 3'b000})
      else $error("message number not eight times the selector");
   a_scan_start_ok: assert property (scan_req_i && !scan_busy_o && ctrl_q[`CTRL_SCAN_EN_BIT]
      |=> scan_busy_o ##1 scan_valid_o)
      else $error("accepted scan did not start on time");
   a_scan_off_drop: assert property (scan_req_i && !scan_busy_o && !ctrl_q[`CTRL_SCAN_EN_BIT] |=> !scan_busy_o)
      else $error("scan started while disabled");
   a_byte_hold_stall: assert property (scan_valid_o && !scan_ready_i |=> scan_valid_o && $stable(scan_byte_o))
      else $error("scan byte changed while stalled");
   a_busy_eight_min: assert property ($rose(scan_busy_o) |-> scan_busy_o [*8])
      else $error("scan busy shorter than eight bytes");
   c_scan_taken: cover property ($rose(scan_busy_o));
   c_scan_stall: cover property (scan_valid_o && !scan_ready_i);
   c_tune_enter: cover property ($rose(tuning_mode_o));
endmodule
bind pulse_input_status_ports pis_chk pis_chk_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
   .low_pair_mode_switch_i(low_pair_mode_switch_i), .low_pair_count_on_i(low_pair_count_on_i),
   .sixteen_way_selector_i(sixteen_way_selector_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scan_req_i(scan_req_i),
   .scan_busy_o(scan_busy_o), .scan_valid_o(scan_valid_o), .scan_ready_i(scan_ready_i),
   .scan_byte_o(scan_byte_o), .tuning_mode_o(tuning_mode_o), .display_msg_o(display_msg_o));
`default_nettype wire

// File: scan_poller.sv
// Purpose: Controller side of the scan stream: request, then collect bytes.
// Assumes: Requests are only issued while the block is not busy.
// Notes: Can stall the reader after four bytes to fill the FIFO.
`timescale 1ns/1ps
`default_nettype none
module scan_poller
(
   input wire logic core_clk_i,
   input wire logic scan_valid_i,
   input wire logic [7:0] scan_byte_i,
   output logic scan_req_o,
   output logic scan_ready_o
);
   // Bytes of the last scan, in arrival order
   logic [7:0] got [0:7];
   initial
   begin
      scan_req_o = 1'b0;
      scan_ready_o = 1'b0;
   end
   // One poll; n returns how many bytes came back before the guard ran out
   task automatic poll(input int stall, output int n);
      int guard;
      n = 0;
      guard = 0;
      @(posedge core_clk_i);
      scan_req_o <= 1'b1;
      scan_ready_o <= 1'b1;
      @(posedge core_clk_i);
      scan_req_o <= 1'b0;
      while (n < 8 && guard < 100)
      begin
         @(posedge core_clk_i);
         guard++;
         // Take a byte only at an edge where both sides agree
         if (scan_valid_i === 1'b1 && scan_ready_o)
         begin
            got[n] = scan_byte_i;
            n++;
            // Stall after half the scan so the FIFO fills up
            if (n == 4 && stall > 0)
            begin
               scan_ready_o <= 1'b0;
               repeat (stall) @(posedge core_clk_i);
               scan_ready_o <= 1'b1;
            end
         end
      end
      @(posedge core_clk_i);
      scan_ready_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: pulse_input_status_ports_tb.sv
// Purpose: Register, scan and operator key tests of the pulse input block.
// Assumes: Pins settle in the logic within five clocks of a change.
// Notes: clk_en_i is held high throughout; freezing is not exercised.
`timescale 1ns/1ps
`include "pulse_input_status_consts.vh"
`default_nettype none
module pulse_input_status_ports_tb;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] pulse_in = 4'h0;
   // Pair pins as {high mode, low mode, high count on, low count on}
   logic [3:0] pins = 4'h0;
   // Keys as {step, minus, plus}
   logic [2:0] keys = 3'h0;
   logic [3:0] sel = 4'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   wire scan_req;
   wire scan_busy;
   wire scan_valid;
   wire scan_ready;
   wire tune;
   wire [7:0] rdata;
   wire [7:0] sbyte;
   wire [7:0] msg;
   wire [7:0] dval;
   int error_cnt = 0;
   int n_compared = 0;
   int n;
   int i;
   always #50 core_clk_i = ~core_clk_i;
   pulse_input_status_ports pulse_input_status_ports_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(1'b1), .pulse_in_i(pulse_in), .low_pair_mode_switch_i(pins[2]),
      .high_pair_mode_switch_i(pins[3]), .low_pair_count_on_i(pins[0]), .high_pair_count_on_i(pins[1]),
      .plus_key_switch_i(keys[0]), .minus_key_switch_i(keys[1]), .step_key_switch_i(keys[2]),
      .sixteen_way_selector_i(sel), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .scan_req_i(scan_req), .scan_busy_o(scan_busy), .scan_valid_o(scan_valid),
      .scan_ready_i(scan_ready), .scan_byte_o(sbyte), .tuning_mode_o(tune), .display_msg_o(msg),
      .display_value_o(dval));
   scan_poller scan_poller_i (.core_clk_i(core_clk_i), .scan_valid_i(scan_valid), .scan_byte_i(sbyte),
      .scan_req_o(scan_req), .scan_ready_o(scan_ready));
   // Count and report one comparison
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   // One-cycle read strobe; data only stand in the following cycle
   task automatic cmp_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 check(what, rdata, exp);
   endtask
   // Hold a key past the synchroniser and edge detector, then release it
   task automatic press(input int k);
      @(posedge core_clk_i);
      keys[k] <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      keys[k] <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1;
   endtask
   // Send cnt pulses on one channel, each wide enough to survive sync
   task automatic pulses(input int ch, input int cnt);
      repeat (cnt)
      begin
         @(posedge core_clk_i);
         pulse_in[ch] <= 1'b1;
         repeat (3) @(posedge core_clk_i);
         pulse_in[ch] <= 1'b0;
         repeat (2) @(posedge core_clk_i);
      end
   endtask
   // Poll once and compare all eight bytes, byte 0 in the low bits
   task automatic scan_chk(input logic [63:0] exp, input int stall);
      scan_poller_i.poll(stall, n);
      check("scan byte count", n[7:0], 8'h08);
      for (int b = 0; b < 8; b++)
         check("scan byte", scan_poller_i.got[b], exp[8*b +: 8]);
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog: the tests need about 600 cycles
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      error_cnt++;
      $display("Watchdog expired");
      summarize();
   end
   // Main test sequence
   initial
   begin
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      cmp_reg(`CTRL_PORT_ADDR, `CTRL_RESET, "control reset");
      cmp_reg(4'h5, 8'h00, "unmapped read");
      for (i = 0; i < 16; i++)
      begin
         @(posedge core_clk_i);
         pins <= i[3:0];
         repeat (4) @(posedge core_clk_i);
         cmp_reg(`MODE_PORT_ADDR, {4'h0, i[3:0]}, "mode port");
      end
      wr_reg(`MODE_PORT_ADDR, 8'h00);
      cmp_reg(`MODE_PORT_ADDR, 8'h0F, "mode port after write");
      $display("Test mode port done");
      for (i = 0; i < 16; i++)
      begin
         @(posedge core_clk_i);
         sel <= i[3:0];
         repeat (4) @(posedge core_clk_i);
         cmp_reg(`SWITCH_PORT_ADDR, {4'h0, i[3:0]}, "switch port");
         check("tuning flag", {7'h00, tune}, {7'h00, i >= 9});
      end
      @(posedge core_clk_i);
      sel <= 4'h2;
      keys <= 3'h7;
      repeat (4) @(posedge core_clk_i);
      cmp_reg(`SWITCH_PORT_ADDR, 8'h72, "switch keys");
      keys <= 3'h0;
      $display("Test switch port done");
      // Both pairs totalizing with counting on, channel c gets c+1 pulses
      pins <= 4'h3;
      for (i = 0; i < 4; i++)
         pulses(i, i + 1);
      repeat (5) @(posedge core_clk_i);
      scan_chk(64'h0004_0003_0002_0001, 6);
      wr_reg(`CTRL_PORT_ADDR, 8'h02);
      cmp_reg(`CTRL_PORT_ADDR, 8'h02, "control write");
      scan_poller_i.poll(0, n);
      check("disabled scan bytes", n[7:0], 8'h00);
      pulses(3, 2);
      wr_reg(`CTRL_PORT_ADDR, `CTRL_RESET);
      $display("Test totalizing scan done");
      // Low pair to rate: the first enable edge restarts, the second captures
      @(posedge core_clk_i);
      pins <= 4'h4;
      repeat (5) @(posedge core_clk_i);
      pins <= 4'h5;
      repeat (5) @(posedge core_clk_i);
      pins <= 4'h4;
      pulses(0, 3);
      pulses(2, 1);
      @(posedge core_clk_i);
      pins <= 4'h5;
      repeat (6) @(posedge core_clk_i);
      scan_chk(64'h0004_0004_0000_0003, 0);
      $display("Test rate scan done");
      // Normal readout at selector 8 shows the mode port
      sel <= 4'h8;
      repeat (5) @(posedge core_clk_i);
      press(2);
      check("readout value", dval, 8'h05);
      check("readout message", msg, 8'h40);
      sel <= 4'h9;
      repeat (5) @(posedge core_clk_i);
      press(2);
      check("edit message", msg, 8'hC8);
      check("edit start value", dval, 8'h00);
      press(0);
      press(0);
      check("after plus", dval, 8'h02);
      press(1);
      check("after minus", dval, 8'h01);
      press(2);
      check("view message", msg, 8'h48);
      press(2);
      check("saved value", dval, 8'h01);
      $display("Test keys done");
      summarize();
   end
endmodule
`default_nettype wire
